// ==== core/pha_arbiter.sv ====
/*
 * PCI arbitration sideband: grants, hold handshake, lock, parity, error, clock run.
 * Assumes all inputs synchronous to clk; rst_n is the bus reset.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Lock honoured only for processor cycles
// - PCI initiator locks are not supported
// - Non-exclusive traffic proceeds during lock
// - One active-low grant per master
// - Hold drains buffers, then takes host bus
// - Hold acknowledge after drain completes
// - Passive release keeps hold request asserted
// - Even parity over data and command
// - System error asserted on reported errors
// - Clock run open drain, also sampled
// - Clock run undriven after reset release
// - Bus reset acts asynchronously
// - Bus signals tri-state during reset
module pha_arbiter #(
   parameter int NMST = pha_pkg::NUM_MASTERS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NMST-1:0] reqN,
   output logic [NMST-1:0] gntN,
   output logic [NMST-1:0] gntOeN,
   input wire logic bridge_hold_req_n,
   output logic bridge_hold_ack_n,
   output logic holdAckOeN,
   input wire logic frameN,
   input wire logic irdyN,
   input wire logic cpuLockReq,
   input wire logic bus_lock_n_in,
   output logic bus_lock_n_out,
   output logic busLockOeN,
   input wire logic [31:0] adIn,
   input wire logic [3:0] cbeIn,
   input wire logic parIn,
   input wire logic parCheck,
   input wire logic parDrive,
   output logic parOut,
   output logic parOeN,
   output logic parErr,
   input wire logic sysErrEvt,
   output logic sysErrOut,
   output logic sysErrOeN,
   input wire logic clkNeeded,
   input wire logic clkRunIn,
   output logic clkRunOut,
   output logic clkRunOeN,
   output logic clkRunSeen,
   input wire logic memWrEmpty,
   input wire logic postEmpty,
   input wire logic hostBusAck,
   output logic memWrFlush,
   output logic postFlush,
   output logic hostBusReq,
   output logic lockedOwner
);
   // Drain handshake shared with the hold sequencer
   pha_drain_if drn ();

   // Arbiter states, one-hot
   typedef enum logic [3:0] {
      A_IDLE = 4'h1,
      A_MST = 4'h2,
      A_HOLD = 4'h4,
      A_PREL = 4'h8
   } pha_arb_e;

   pha_arb_e state_ff, nxt_state;
   logic [2:0] owner_ff, nxt_owner;      // Granted master index
   logic [2:0] rrPtr_ff, nxt_rrPtr;      // Round robin start point
   logic [7:0] latCnt_ff, nxt_latCnt;    // Grant hold timer
   logic [NMST-1:0] req;                 // Active-high requests
   logic [2:0] pick;                     // Next master chosen
   logic pickValid;                      // Some master requesting
   logic busIdle;                        // No frame or initiator ready
   logic lockOwn_ff, nxt_lockOwn;        // Processor holds exclusive lock
   logic parity;                         // Even parity of bus lines
   logic parErr_ff, nxt_parErr;          // Captured parity error
   logic sysErr_ff, nxt_sysErr;          // System error pulse
   logic [3:0] runCnt_ff, nxt_runCnt;    // Clock run hold counter
   logic runSync_ff, nxt_runSync;        // Sampled clock run level

   // Timer reloads sized to their counters
   localparam logic [7:0] LAT_MAX = 8'(pha_pkg::LATENCY_CYCLES);
   localparam logic [3:0] RUN_MAX = 4'(pha_pkg::CLKRUN_CYCLES);

   // Request and bus idle decode
   assign req = ~reqN;
   assign busIdle = frameN && irdyN;

   // Round robin pick from rrPtr
   always_comb begin
      pick = 3'h0;
      pickValid = 1'b0;
      for (int i = NMST - 1; i >= 0; i--) begin
         if (req[(int'(rrPtr_ff) + i) % NMST]) begin
            pick = 3'((int'(rrPtr_ff) + i) % NMST);
            pickValid = 1'b1;
         end
      end
   end

   // Hold handshake toward the sequencer
   assign drn.holdReq = !bridge_hold_req_n;
   assign drn.released = (state_ff == A_PREL);

   pha_hold_seq u_seq (
      .clk(clk),
      .rst_n(rst_n),
      .drn(drn),
      .memWrEmpty(memWrEmpty),
      .postEmpty(postEmpty),
      .hostBusAck(hostBusAck),
      .memWrFlush(memWrFlush),
      .postFlush(postFlush),
      .hostBusReq(hostBusReq)
   );

   // Arbiter next state; hold has priority over masters
   always_comb begin
      nxt_state = state_ff;
      nxt_owner = owner_ff;
      nxt_rrPtr = rrPtr_ff;
      nxt_latCnt = (latCnt_ff != 8'h00) ? latCnt_ff - 8'h01 : 8'h00;
      unique case (state_ff)
         A_IDLE: begin
            // Hold acknowledged only once sequencer is ready
            if (drn.holdReady && drn.holdReq && busIdle) begin
               nxt_state = A_HOLD;
            end else if (pickValid && !drn.holdReq) begin
               nxt_state = A_MST;
               nxt_owner = pick;
               nxt_latCnt = LAT_MAX;
               nxt_rrPtr = (pick == 3'(NMST - 1)) ? 3'h0 : pick + 3'h1;
            end
         end
         A_MST: begin
            // Release with bus idle when request drops, or when timer expires with any request (owner's own included) or hold pending
            if (!req[owner_ff] || ((latCnt_ff == 8'h00) && busIdle
                && (pickValid || drn.holdReq))) begin
               if (busIdle) nxt_state = A_IDLE;
            end
         end
         A_HOLD: begin
            if (!drn.holdReq) begin
               nxt_state = A_IDLE;
            end else if (pickValid && busIdle) begin
               // Passive release: lend bus while hold request remains
               nxt_state = A_PREL;
               nxt_owner = pick;
               nxt_latCnt = LAT_MAX;
            end
         end
         A_PREL: begin
            if (!drn.holdReq) begin
               nxt_state = A_IDLE;
            end else if (!req[owner_ff] && busIdle) begin
               nxt_state = A_HOLD;
            end
         end
         default: nxt_state = A_IDLE;
      endcase
   end

   // Arbiter registers; asynchronous bus reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= A_IDLE;
         owner_ff <= 3'h0;
         rrPtr_ff <= 3'h0;
         latCnt_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         owner_ff <= nxt_owner;
         rrPtr_ff <= nxt_rrPtr;
         latCnt_ff <= nxt_latCnt;
      end
   end

   // One grant per master, only one at a time
   generate
      for (genvar g = 0; g < NMST; g++) begin : gGnt
         assign gntN[g] = !(((state_ff == A_MST) || (state_ff == A_PREL))
                            && (owner_ff == 3'(g)));
      end
   endgenerate
   assign bridge_hold_ack_n = !(state_ff == A_HOLD);

   // Lock tracks processor cycles only; PCI locks ignored
   always_comb begin
      nxt_lockOwn = lockOwn_ff;
      if (cpuLockReq) nxt_lockOwn = 1'b1;
      else if (frameN && irdyN && !cpuLockReq) nxt_lockOwn = 1'b0;
   end
   // Parity, error and clock run next values
   always_comb begin
      parity = ^{adIn, cbeIn};
      nxt_parErr = parCheck && (parity != parIn);
      nxt_sysErr = sysErrEvt || parErr_ff;
      nxt_runSync = clkRunIn;
      if (clkNeeded) nxt_runCnt = RUN_MAX;
      else if (runCnt_ff != 4'h0) nxt_runCnt = runCnt_ff - 4'h1;
      else nxt_runCnt = 4'h0;
   end

   // Sideband registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lockOwn_ff <= 1'b0;
         parErr_ff <= 1'b0;
         sysErr_ff <= 1'b0;
         runSync_ff <= 1'b1;
         runCnt_ff <= 4'h0;
      end else begin
         lockOwn_ff <= nxt_lockOwn;
         parErr_ff <= nxt_parErr;
         sysErr_ff <= nxt_sysErr;
         runSync_ff <= nxt_runSync;
         runCnt_ff <= nxt_runCnt;
      end
   end

   // Lock driven only for processor owner; others keep flowing
   assign bus_lock_n_out = 1'b0;
   assign busLockOeN = !(rst_n && lockOwn_ff);
   assign lockedOwner = lockOwn_ff && !bus_lock_n_in;
   assign parOut = parity;
   assign parOeN = !(rst_n && parDrive);
   assign parErr = parErr_ff;
   assign sysErrOut = 1'b0;
   assign sysErrOeN = !(rst_n && sysErr_ff);
   assign clkRunOut = 1'b0;
   assign clkRunOeN = !(rst_n && (runCnt_ff != 4'h0));
   assign clkRunSeen = !runSync_ff;
   // Grant pins float during reset
   assign gntOeN = {NMST{!rst_n}};
   assign holdAckOeN = !rst_n;

   // Never more than one owner of the bus
   AST_ONEGNT: assert property (@(posedge clk) disable iff (!rst_n)
      $countones({~gntN, !bridge_hold_ack_n}) <= 1)
      else $error("more than one grant");
   // Acknowledge only while the sequencer holds the host bus
   AST_ACKRDY: assert property (@(posedge clk) disable iff (!rst_n)
      !bridge_hold_ack_n |-> drn.holdReady)
      else $error("hold ack without drain");
   // Master 0's grant follows its own request
   AST_GNTREQ: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(gntN[0]) |-> $past(!reqN[0]))
      else $error("grant without request");
   // Passive release only while the hold request stays low
   AST_PREL: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == A_PREL) |-> $past(!bridge_hold_req_n))
      else $error("passive release without hold");
   // Bad parity is flagged, then reported as a system error
   AST_PAR: assert property (@(posedge clk) disable iff (!rst_n)
      parCheck && (parIn != ^{adIn, cbeIn}) |=> parErr ##1 !sysErrOeN)
      else $error("parity error not flagged");
   // A system error event drives the error line
   AST_SERR: assert property (@(posedge clk) disable iff (!rst_n)
      sysErrEvt |=> !sysErrOeN)
      else $error("system error not driven");
   // Clock request held for the whole hold time
   AST_CRUN: assert property (@(posedge clk) disable iff (!rst_n)
      clkNeeded |=> !clkRunOeN [*4])
      else $error("clock run not held");
   // Clock run left undriven as reset lifts
   AST_CRUNRST: assert property (@(posedge clk)
      $rose(rst_n) |-> clkRunOeN)
      else $error("clock run driven at reset release");
   // Lock drive starts only on a processor request
   AST_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(busLockOeN) |-> $past(cpuLockReq))
      else $error("lock driven without processor");
   // Reset floats every bus pin the block can drive
   AST_TRIST: assert property (@(posedge clk)
      !rst_n |-> (&gntOeN) && holdAckOeN && busLockOeN && parOeN && sysErrOeN && clkRunOeN)
      else $error("bus pin driven during reset");
   // A pending hold request keeps masters off the bus
   AST_HOLDFIRST: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == A_IDLE) && !bridge_hold_req_n |=> (state_ff != A_MST))
      else $error("master granted over pending hold");
   // Acknowledge drops once the hold request is gone
   AST_ACKDROP: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == A_HOLD) && bridge_hold_req_n |=> bridge_hold_ack_n)
      else $error("hold ack kept after request");
   // Masters still get the bus while the processor lock stands
   AST_LOCKTRAF: assert property (@(posedge clk) disable iff (!rst_n)
      lockOwn_ff && pickValid && bridge_hold_req_n && (state_ff == A_IDLE)
      |=> (state_ff == A_MST))
      else $error("traffic blocked by lock");
   // Lock falls once the processor lets go on an idle bus
   AST_LOCKDROP: assert property (@(posedge clk) disable iff (!rst_n)
      lockOwn_ff && !cpuLockReq && busIdle |=> busLockOeN)
      else $error("lock kept after processor release");
   // Clock run released once the hold time has run out
   AST_CRUNIDLE: assert property (@(posedge clk) disable iff (!rst_n)
      (runCnt_ff == 4'h0) && !clkNeeded |=> clkRunOeN)
      else $error("clock run driven without need");
endmodule
`default_nettype wire

// ==== core/pha_drain_if.sv ====
/*
 * Interface carrying the hold drain sequence between arbiter and sequencer.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
interface pha_drain_if;
   logic holdReq;      // Expansion bridge wants the bus
   logic released;     // Passive release seen
   logic holdReady;    // Buffers drained and host bus held
   modport arb (output holdReq, output released, input holdReady);
   modport seq (input holdReq, input released, output holdReady);
endinterface
`default_nettype wire

// ==== core/pha_hold_seq.sv ====
/*
 * Hold sequencer: drains write buffers, posting buffers, then takes the host bus.
 * Assumes buffer status and host bus acknowledge are synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module pha_hold_seq (
   input wire logic clk,
   input wire logic rst_n,
   pha_drain_if.seq drn,
   input wire logic memWrEmpty,
   input wire logic postEmpty,
   input wire logic hostBusAck,
   output logic memWrFlush,
   output logic postFlush,
   output logic hostBusReq
);
   // One-hot sequence states
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_MEMW = 5'h02,
      S_POST = 5'h04,
      S_HOST = 5'h08,
      S_HELD = 5'h10
   } pha_seq_e;
   pha_seq_e state_ff, nxt_state;

   // Next state: drain memory writes, then posting buffers, then host bus
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         S_IDLE: if (drn.holdReq) nxt_state = S_MEMW;
         S_MEMW: if (!drn.holdReq) nxt_state = S_IDLE;
                 else if (memWrEmpty) nxt_state = S_POST;
         S_POST: if (!drn.holdReq) nxt_state = S_IDLE;
                 else if (postEmpty) nxt_state = S_HOST;
         S_HOST: if (!drn.holdReq) nxt_state = S_IDLE;
                 else if (hostBusAck) nxt_state = S_HELD;
         // Passive release keeps host bus held while request stays
         S_HELD: if (!drn.holdReq) nxt_state = S_IDLE;
         default: nxt_state = S_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= S_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign memWrFlush = (state_ff == S_MEMW);
   assign postFlush = (state_ff == S_POST);
   assign hostBusReq = (state_ff == S_HOST) || (state_ff == S_HELD);
   assign drn.holdReady = (state_ff == S_HELD);

   // Ready only right after the host bus acknowledge in the host stage
   AST_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(drn.holdReady) |-> $past(hostBusAck) && $past(state_ff == S_HOST))
      else $error("hold ready without host bus");
   // Passive release lends the bus without dropping the held host bus
   AST_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      drn.released |-> drn.holdReady)
      else $error("host bus let go during passive release");
endmodule
`default_nettype wire

// ==== core/pha_pkg.sv ====
/*
 * Shared constants for the bus arbitration sideband block.
 * Assumes a single 25 MHz clock domain and active-low bus signals.
 */
package pha_pkg;
   localparam int NUM_MASTERS = 5;                   // Request/grant pairs
   localparam int CLK_PERIOD_NS = 40;                // Clock period
   localparam int LATENCY_TIMER_NS = 640;            // Grant hold limit under contention
   localparam int LATENCY_CYCLES = (LATENCY_TIMER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CLKRUN_HOLD_NS = 160;              // Time to keep clock request after activity
   localparam int CLKRUN_CYCLES = (CLKRUN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] GRANT_NONE = 5'h1f;        // All grants released
   localparam int PARITY_WIDTH = 36;                 // 32 data plus 4 command lines
endpackage

// ==== sim/pha_far_model.sv ====
/* Far side of the arbiter: buffers, host bus and clock run pull-up.
   Assumes the arbiter's clock and reset; the bench picks slow or fast replies. */
`timescale 1ns/1ps
`default_nettype none
module pha_far_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic fill,
   input wire logic memWrFlush,
   input wire logic postFlush,
   input wire logic hostBusReq,
   input wire logic clkRunOut,
   input wire logic clkRunOeN,
   input wire logic cenDrive,
   output logic memWrEmpty,
   output logic postEmpty,
   output logic hostBusAck,
   output logic clkRunIn
);
   logic [2:0] waitCnt; // Cycles before the next step may complete
   // Buffers drain one after the other, then the host bus is handed over
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         memWrEmpty <= 1'b1;
         postEmpty <= 1'b1;
         hostBusAck <= 1'b0;
         waitCnt <= 3'h0;
      end else if (fill) begin
         memWrEmpty <= 1'b0;
         postEmpty <= 1'b0;
      end else if (waitCnt != 3'h0) begin
         waitCnt <= waitCnt - 3'h1;
      end else begin
         waitCnt <= slow ? 3'h4 : 3'h1;
         if (memWrFlush) memWrEmpty <= 1'b1;
         else if (postFlush) postEmpty <= 1'b1;
         hostBusAck <= hostBusReq;
      end
   end
   // Open-drain line with pull-up; central resource may pull it low
   assign clkRunIn = ~cenDrive & (clkRunOeN | clkRunOut);
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
/* Self-checking bench for the arbitration sideband.
   Assumes the far-side model; inputs change on the falling clock edge. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk, rst_n, holdReqN, frameN, irdyN, cpuLockReq, parIn, parCheck, parDrive;
   logic sysErrEvt, clkNeeded, slow, fill, cenDrive, mstLockN, lockWire;
   logic [4:0] reqN, gntN, gntOeN;
   logic [31:0] adIn;
   logic [3:0] cbeIn;
   logic holdAckN, holdAckOeN, lockOut, lockOeN, parOut, parOeN, parErr, sysErrOut;
   logic sysErrOeN, clkRunOut, clkRunOeN, clkRunSeen, clkRunIn, memWrEmpty, postEmpty;
   logic hostBusAck, memWrFlush, postFlush, hostBusReq, lockedOwner, sawMw, sawPf, sawHb;
   int fails, checked, cycles, n, i;
   // Lock line: pull-up, bridge and a master may pull it low
   assign lockWire = mstLockN & (lockOeN | lockOut);
   pha_arbiter i_pha_arbiter (.clk(clk), .rst_n(rst_n), .reqN(reqN), .gntN(gntN),
      .gntOeN(gntOeN), .bridge_hold_req_n(holdReqN), .bridge_hold_ack_n(holdAckN),
      .holdAckOeN(holdAckOeN), .frameN(frameN), .irdyN(irdyN), .cpuLockReq(cpuLockReq),
      .bus_lock_n_in(lockWire), .bus_lock_n_out(lockOut), .busLockOeN(lockOeN),
      .adIn(adIn), .cbeIn(cbeIn), .parIn(parIn), .parCheck(parCheck), .parDrive(parDrive),
      .parOut(parOut), .parOeN(parOeN), .parErr(parErr), .sysErrEvt(sysErrEvt),
      .sysErrOut(sysErrOut), .sysErrOeN(sysErrOeN), .clkNeeded(clkNeeded),
      .clkRunIn(clkRunIn), .clkRunOut(clkRunOut), .clkRunOeN(clkRunOeN),
      .clkRunSeen(clkRunSeen), .memWrEmpty(memWrEmpty), .postEmpty(postEmpty),
      .hostBusAck(hostBusAck), .memWrFlush(memWrFlush), .postFlush(postFlush),
      .hostBusReq(hostBusReq), .lockedOwner(lockedOwner));
   pha_far_model i_pha_far_model (.clk(clk), .rst_n(rst_n), .slow(slow), .fill(fill),
      .memWrFlush(memWrFlush), .postFlush(postFlush), .hostBusReq(hostBusReq),
      .clkRunOut(clkRunOut), .clkRunOeN(clkRunOeN), .cenDrive(cenDrive),
      .memWrEmpty(memWrEmpty), .postEmpty(postEmpty), .hostBusAck(hostBusAck),
      .clkRunIn(clkRunIn));
   // Compares and counts
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t ns: %s", $time, m);
      end
   endtask
   task automatic wrap_up;
      $display("Checks %0d, errors %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Each master alone is granted on its own line
   task automatic t_masters;
      for (i = 0; i < 5; i++) begin
         reqN = ~(5'h01 << i);
         for (n = 0; n < 30 && gntN[i] !== 1'b0; n++) @(negedge clk);
         cmp({holdAckN, gntN}, {1'b1, reqN}, "single grant");
         reqN = 5'h1f;
         for (n = 0; n < 30 && gntN !== 5'h1f; n++) @(negedge clk);
         cmp(gntN, 5'h1f, "grant released");
      end
      reqN = 5'h00;
      repeat (4) @(negedge clk);
      cmp(8'($countones(~gntN)), 8'h01, "one grant under contention");
      // Timer hands the bus on: counted from the fourth cycle of contention
      for (n = 0; n < 30 && gntN !== 5'h1d; n++) @(negedge clk);
      cmp(8'(n), 8'(pha_pkg::LATENCY_CYCLES - 1), "timer hand-over time");
      cmp(gntN, 5'h1d, "grant rotates on timer");
   endtask
   // Reset pulled mid-grant acts without a clock edge
   task automatic t_async;
      reqN = 5'h1f;
      #7 rst_n = 1'b0;
      #1 cmp(gntN & gntOeN, 5'h1f, "async reset");
      @(negedge clk) rst_n = 1'b1;
      @(negedge clk) cmp(clkRunOeN, 1'b1, "clock run idle after reset");
   endtask
   // Hold: drain, host bus, acknowledge, then passive release
   task automatic t_hold;
      fill = 1'b1;
      @(negedge clk) fill = 1'b0;
      holdReqN = 1'b0;
      {sawMw, sawPf, sawHb} = 3'h0;
      for (n = 0; n < 80 && holdAckN !== 1'b0; n++) begin
         @(negedge clk);
         sawMw |= memWrFlush;
         sawPf |= postFlush;
         sawHb |= hostBusAck & hostBusReq;
      end
      cmp({sawMw, sawPf, sawHb, memWrEmpty, postEmpty}, 5'h1f, "drain before ack");
      cmp({holdAckN, gntN}, 6'h1f, "hold granted alone");
      reqN = 5'h1b;
      for (n = 0; n < 30 && gntN[2] !== 1'b0; n++) @(negedge clk);
      cmp({holdAckN, gntN}, 6'h3b, "passive release to master");
      reqN = 5'h1f;
      sawMw = 1'b0;
      for (n = 0; n < 30 && holdAckN !== 1'b0; n++) @(negedge clk) sawMw |= memWrFlush;
      cmp({holdAckN, sawMw}, 2'h0, "ack back without drain");
      holdReqN = 1'b1;
      for (n = 0; n < 30 && holdAckN !== 1'b1; n++) @(negedge clk);
      cmp(holdAckN, 1'b1, "hold ack dropped");
   endtask
   // Parity drive, good and bad parity check, then system error
   task automatic t_parity(input logic [35:0] v, input logic bad);
      {adIn, cbeIn} = v;
      parDrive = 1'b1;
      @(negedge clk) cmp({parOeN, parOut}, {1'b0, ^v}, "parity out");
      parDrive = 1'b0;
      parIn = (^v) ^ bad;
      parCheck = 1'b1;
      @(negedge clk) parCheck = 1'b0;
      cmp(parErr, bad, "parity error flag");
      @(negedge clk) cmp(sysErrOeN, !bad, "system error on parity");
      sysErrEvt = 1'b1;
      @(negedge clk) sysErrEvt = 1'b0;
      cmp({sysErrOeN, sysErrOut}, 2'h0, "system error event");
      @(negedge clk) cmp(sysErrOeN, 1'b1, "system error one cycle");
   endtask
   // Clock run request, hold time and sampling of the line
   task automatic t_clkrun;
      clkNeeded = 1'b1;
      cenDrive = 1'b1;
      repeat (2) @(negedge clk);
      cmp({clkRunOeN, clkRunOut, clkRunSeen}, 3'h1, "clock run driven");
      {clkNeeded, cenDrive} = 2'h0;
      repeat (3) @(negedge clk);
      cmp(clkRunOeN, 1'b0, "clock run held");
      for (n = 0; n < 8 && clkRunOeN !== 1'b1; n++) @(negedge clk);
      @(negedge clk) cmp({clkRunOeN, clkRunSeen}, 2'h2, "clock run released");
      cenDrive = 1'b1;
      repeat (2) @(negedge clk);
      cmp({clkRunOeN, clkRunSeen}, 2'h3, "central clock run seen");
      cenDrive = 1'b0;
   endtask
   // Processor lock, traffic during lock, master lock ignored
   task automatic t_lock;
      cpuLockReq = 1'b1;
      for (n = 0; n < 10 && lockOeN !== 1'b0; n++) @(negedge clk);
      cmp({lockOeN, lockOut}, 2'h0, "processor lock");
      cmp(lockedOwner, 1'b1, "processor owns lock");
      reqN = 5'h17;
      for (n = 0; n < 30 && gntN[3] !== 1'b0; n++) @(negedge clk);
      cmp(gntN, 5'h17, "grant during lock");
      {reqN, cpuLockReq} = 6'h3e;
      for (n = 0; n < 30 && lockOeN !== 1'b1; n++) @(negedge clk);
      mstLockN = 1'b0;
      repeat (4) @(negedge clk);
      cmp({lockOeN, lockedOwner}, 2'h2, "no lock for masters");
      mstLockN = 1'b1;
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      {rst_n, fill, slow, cpuLockReq, parCheck, parDrive, sysErrEvt, clkNeeded} = 8'h0;
      {holdReqN, frameN, irdyN, mstLockN, parIn, cenDrive} = 6'h3c;
      {reqN, adIn, cbeIn} = {5'h1f, 36'h0};
      repeat (10) @(negedge clk);
      cmp({gntOeN, holdAckOeN, parOeN, sysErrOeN}, 8'hff, "tristate in reset");
      cmp({gntN, clkRunOeN, lockOeN}, 7'h7f, "idle in reset");
      rst_n = 1'b1;
      @(negedge clk) cmp(clkRunOeN, 1'b1, "clock run undriven");
      t_masters();
      t_async();
      t_hold();
      slow = 1'b1;
      t_hold();
      t_parity(36'h0_0000_0000, 1'b1);
      t_parity(36'hf_ffff_fffe, 1'b0);
      t_parity(36'h5_a5a5_3c3c, 1'b1);
      t_clkrun();
      t_lock();
      wrap_up();
   end
endmodule
`default_nettype wire
